// ---- dv/cad_core_props.sv ----
// port checker of the core addressing decoder
`timescale 1ns/1ns
module cad_core_props (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // program side
    input wire logic [cad_pkg::PC_W-1:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    // data side
    input wire cad_pkg::cad_dreq_type data_req_o,
    input wire logic [7:0] data_rdata_i,
    // core state
    input wire logic [7:0] acc_o,
    input wire logic zero_o,
    input wire logic carry_o,
    input wire logic [cad_pkg::PC_W-1:0] instr_addr_o
);
    import cad_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // ============================================================
    // sequences
    // read then write next cycle only happens in a bit set or clear
    sequence s_rmw;
        data_req_o.rd ##1 data_req_o.wr;
    endsequence
    // ============================================================
    // properties
    property p_refused;
        (data_req_o.rd || data_req_o.wr) |->
            (data_req_o.addr != ADDR_ACC) && (data_req_o.addr[7:2] != WREG_PAGE);
    endproperty
    property p_excl;
        !(data_req_o.rd && data_req_o.wr);
    endproperty
    property p_rd_gap;
        data_req_o.rd |=> (!data_req_o.rd) [*3];
    endproperty
    property p_wr_gap;
        data_req_o.wr |=> (!data_req_o.wr) [*3];
    endproperty
    property p_rmw_one;
        s_rmw |-> $stable(data_req_o.addr) &&
            ($countones(data_req_o.wdata ^ $past(data_rdata_i)) <= 1);
    endproperty
    property p_rmw_carry;
        s_rmw |-> (data_req_o.wdata == $past(data_rdata_i)) ||
            (carry_o == |($past(data_rdata_i) & ~data_req_o.wdata));
    endproperty
    property p_acc_zero;
        $changed(acc_o) |-> zero_o == (acc_o == 8'h00);
    endproperty
    property p_zero_acc;
        $changed(zero_o) |-> zero_o == (acc_o == 8'h00);
    endproperty
    property p_first_fetch;
        $rose(rst_b_i) |-> prog_addr_o == 12'h000;
    endproperty
    // ============================================================
    // assertions
    a_refused: assert property (p_refused) else $error("internal address on bus");
    a_excl: assert property (p_excl) else $error("read and write together");
    a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
    a_wr_gap: assert property (p_wr_gap) else $error("writes too close");
    a_rmw_one: assert property (p_rmw_one) else $error("bit op changed >1 bit");
    a_rmw_carry: assert property (p_rmw_carry) else $error("carry not old bit");
    a_acc_zero: assert property (p_acc_zero) else $error("zero wrong on load");
    a_zero_acc: assert property (p_zero_acc) else $error("zero moved alone");
    a_first_fetch: assert property (p_first_fetch) else $error("bad first fetch");
endmodule

bind cad_core cad_core_props i_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .data_req_o(data_req_o),
    .data_rdata_i(data_rdata_i), .acc_o(acc_o), .zero_o(zero_o), .carry_o(carry_o),
    .instr_addr_o(instr_addr_o));

// ---- dv/cad_mem_model.sv ----
// program and data space model on the far side of the decoder
`timescale 1ns/1ns
module cad_mem_model (
    // clock
    input wire logic mclk_i,
    // program space
    input wire logic [cad_pkg::PC_W-1:0] prog_addr_i,
    output logic [7:0] prog_data_o,
    // data space
    input wire cad_pkg::cad_dreq_type data_req_i,
    output logic [7:0] data_rdata_o
);
    import cad_pkg::*;
    logic [7:0] rom [0:4095];
    logic [7:0] ram [0:255];
    logic [7:0] last;
    // rom constants answer in the same cycle, no wait states
    assign prog_data_o = rom[prog_addr_i];
    // one 256-byte data space; off-cycle data inverts so a late sample shows
    assign data_rdata_o = data_req_i.rd ? ram[data_req_i.addr] : ~last;
    // writes land at the edge ending the write cycle
    always @(posedge mclk_i) begin
        if (data_req_i.rd) last <= ram[data_req_i.addr];
        if (data_req_i.wr) ram[data_req_i.addr] <= data_req_i.wdata;
    end
    // cleared contents so leftovers never mask a missing write
    initial begin
        last = 8'h00;
        for (int i = 0; i < 4096; i++) rom[i] = 8'h00;
        for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    end
endmodule

// ---- dv/core_addressing_decoder_tb.sv ----
// self-checking bench of the core addressing decoder
`timescale 1ns/1ns
module core_addressing_decoder_tb;
    import cad_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [PC_W-1:0] prog_addr;
    logic [PC_W-1:0] instr_addr;
    logic [7:0] prog_data;
    logic [7:0] rdata;
    logic [7:0] acc;
    cad_dreq_type dreq;
    logic zero;
    logic carry;
    int n_errors = 0;
    int cmp_count = 0;
    // ============================================================
    // design and far side
    cad_core i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .prog_addr_o(prog_addr),
        .prog_data_i(prog_data), .data_req_o(dreq), .data_rdata_i(rdata), .acc_o(acc),
        .zero_o(zero), .carry_o(carry), .instr_addr_o(instr_addr));
    cad_mem_model i_mem (.mclk_i(mclk_i), .prog_addr_i(prog_addr), .prog_data_o(prog_data),
        .data_req_i(dreq), .data_rdata_o(rdata));
    // 25 mhz core clock
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    // ============================================================
    // helpers
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // program bytes sit at consecutive addresses
    task automatic put(input logic [11:0] a, input logic [7:0] q[$]);
        foreach (q[i]) i_mem.rom[a + 12'(i)] = q[i];
    endtask
    // eight reset cycles; the program is loaded before the first fetch edge
    task automatic start();
        @(posedge mclk_i) rst_b_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
    endtask
    // step a fixed cycle budget, then look at the next fetch address
    task automatic adv(input int n, input logic [11:0] pc);
        repeat (n) @(posedge mclk_i);
        #1;
        chk("prog_addr", pc, prog_addr);
    endtask
    // ============================================================
    // scenarios
    task automatic t_load_store();
        start();
        put(12'h000, {8'hd8, 8'h00, 8'hd9, 8'h10, 8'h5a, 8'hd0, 8'h10, 8'hc5,
            8'hd8, 8'h00, 8'hc1, 8'hf4, 8'hd4, 8'h20, 8'he0, 8'hca, 8'h22});
        adv(4, 12'h002);
        chk("zero", 12'h001, 12'(zero));
        adv(4, 12'h005);
        chk("zero", 12'h001, 12'(zero));
        chk("ram10", 12'h05a, 12'(i_mem.ram[8'h10]));
        adv(4, 12'h007);
        chk("acc", 12'h05a, 12'(acc));
        adv(4, 12'h008);
        adv(4, 12'h00a);
        chk("zero", 12'h001, 12'(zero));
        adv(4, 12'h00b);
        chk("acc", 12'h05a, 12'(acc));
        adv(4, 12'h00c);
        adv(4, 12'h00e);
        chk("ram5a", 12'h05a, 12'(i_mem.ram[8'h5a]));
        chk("ram20", 12'h05a, 12'(i_mem.ram[8'h20]));
        chk("carry", 12'h000, 12'(carry));
        // indirect load through the first pointer, an unused opcode, then a taken zero branch
        adv(4, 12'h00f);
        chk("acc", 12'h000, 12'(acc));
        chk("zero", 12'h001, 12'(zero));
        adv(2, 12'h010);
        adv(2, 12'h013);
        chk("instr_addr", 12'h010, instr_addr);
    endtask
    // jump, call, return, both relative edges, bit ops and bit test branch
    task automatic t_branch();
        start();
        i_mem.ram[8'h30] = 8'h00;
        i_mem.ram[8'h31] = 8'h01;
        put(12'h000, {8'h91, 8'h00});
        put(12'h100, {8'h82, 8'h00, 8'h25, 8'h0f});
        put(12'h200, {8'hc8});
        put(12'h113, {8'hab, 8'h30, 8'ha3, 8'h30, 8'hb8, 8'h31, 8'h7f});
        put(12'h197, {8'h7f});
        put(12'h188, {8'h45});
        adv(4, 12'h100);
        adv(4, 12'h200);
        adv(2, 12'h102);
        adv(2, 12'h103);
        adv(2, 12'h113);
        adv(4, 12'h115);
        chk("ram30", 12'h008, 12'(i_mem.ram[8'h30]));
        chk("carry", 12'h000, 12'(carry));
        adv(4, 12'h117);
        chk("ram30", 12'h000, 12'(i_mem.ram[8'h30]));
        chk("carry", 12'h001, 12'(carry));
        adv(5, 12'h197);
        chk("carry", 12'h001, 12'(carry));
        chk("instr_addr", 12'h117, instr_addr);
        adv(2, 12'h188);
        adv(2, 12'h189);
        chk("zero", 12'h000, 12'(zero));
    endtask
    // ============================================================
    // sequence and watchdog
    initial begin
        t_load_store();
        t_branch();
        report_and_stop();
    end
    // both scenarios together need just under ninety cycles
    initial begin
        repeat (1000) @(posedge mclk_i);
        n_errors++;
        report_and_stop();
    end
endmodule

// ---- include/cad_pkg.sv ----
// shared constants and types of the core addressing decoder
package cad_pkg;

    // ============================================================
    // widths and sizes
    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;

    // ============================================================
    // data space map of the registers kept inside the core
    localparam logic [7:0] ADDR_PTR_X = 8'h80;
    localparam logic [7:0] ADDR_WREG_BASE = 8'h80;
    localparam logic [5:0] WREG_PAGE = 6'h20;
    localparam logic [7:0] ADDR_ACC = 8'hff;

    // ============================================================
    // opcode fields
    localparam int OP_DIR_BIT = 4;
    localparam int OP_PTR_BIT = 4;
    localparam int OP_SENSE_BIT = 3;
    localparam int OP_STORE_BIT = 2;
    localparam logic [3:0] CLS_CALL = 4'h8;
    localparam logic [3:0] CLS_JP = 4'h9;
    localparam logic [3:0] CLS_BIT = 4'ha;
    localparam logic [3:0] CLS_BTB = 4'hb;
    localparam logic [3:0] CLS_SHORT = 4'hc;
    localparam logic [3:0] CLS_DIRECT = 4'hd;
    localparam logic [7:0] OP_RET = 8'hc8;
    localparam logic [7:0] OP_LD_A_RR = 8'hd0;
    localparam logic [7:0] OP_LD_RR_A = 8'hd4;
    localparam logic [7:0] OP_LDI_A = 8'hd8;
    localparam logic [7:0] OP_LDI_RR = 8'hd9;
    localparam logic [1:0] REL_NZ = 2'h0;
    localparam logic [1:0] REL_Z = 2'h1;
    localparam logic [1:0] REL_NC = 2'h2;
    localparam logic [1:0] REL_C = 2'h3;

    // ============================================================
    // cycle budgets per instruction
    localparam logic [2:0] CYC_REL = 3'h2;
    localparam logic [2:0] CYC_INH = 3'h2;
    localparam logic [2:0] CYC_LS = 3'h4;
    localparam logic [2:0] CYC_JMP = 3'h4;
    localparam logic [2:0] CYC_BIT = 3'h4;
    localparam logic [2:0] CYC_BTB = 3'h5;

    // ============================================================
    // types
    typedef enum logic [3:0] {
        K_REL, K_CALL, K_JP, K_BIT, K_BTB, K_SHORT, K_DIRECT,
        K_IND, K_LDI_A, K_LDI_D, K_RET, K_NOP
    } cad_kind_type;

    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cad_dreq_type;

endpackage

// ---- logic/cad_core.sv ----
// core addressing decoder: fetch, operand addressing, load/store, bits, jumps
//
// Contract
// - accumulator, working registers, peripherals, RAM and ROM window share one data space.
// - a six-cell stack of 12-bit return addresses serves calls and returns.
// - immediate operand is the program byte right after the opcode.
// - direct mode takes the data address from the byte after the opcode.
// - short direct picks working register 80h-83h from the opcode; one byte.
// - jump and call target joins low opcode nibble with next byte.
// - one-byte relative branch jumps -15 to +16 around itself when condition holds.
// - relative opcode: top bits test, one direction bit, four magnitude bits.
// - false relative condition continues with the following instruction.
// - bit direct takes bit from opcode, byte address from next byte.
// - bit set or bit_clear loads carry with that bit's old value.
// - bit test branch is three bytes: opcode, tested address, displacement.
// - indirect uses pointer 80h or 81h chosen by opcode bit 4; one byte.
// - inherent instructions are one byte with no operand bytes.
// - forty instructions over nine addressing modes in six classes.
// - load_store moves between accumulator and a data byte.
// - load_immediate can target any of the 256 data bytes.
// - load and store take four cycles; lengths one, two or three bytes.
// - load/store update zero, keep carry; immediate-to-data keeps both.
// - jump_absolute and call are two bytes, four cycles, flags untouched.
`timescale 1ns/1ns
module cad_core (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // program space, read combinationally at prog_addr_o
    output logic [cad_pkg::PC_W-1:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    // data space, read combinationally while rd is high
    output cad_pkg::cad_dreq_type data_req_o,
    input wire logic [7:0] data_rdata_i,
    // core state
    output logic [7:0] acc_o,
    output logic zero_o,
    output logic carry_o,
    output logic [cad_pkg::PC_W-1:0] instr_addr_o
);
    import cad_pkg::*;

    // ============================================================
    // state
    logic [PC_W-1:0] pc, next_pc;
    logic [PC_W-1:0] ins_addr, next_ins_addr;
    logic [7:0] op, next_op;
    logic [7:0] b2, next_b2;
    logic [2:0] step, next_step;
    cad_kind_type kind, next_kind;
    logic [7:0] acc, next_acc;
    logic [7:0] wreg [4];
    logic [7:0] next_wreg [4];
    logic zf, next_zf;
    logic cf, next_cf;
    logic take, next_take;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [PC_W-1:0] next_stack [STACK_DEPTH];
    logic [SP_W-1:0] sp, next_sp;
    cad_dreq_type dreq, next_dreq;

    // ============================================================
    // decode helpers
    // opcodes 80h-DFh fall into the six classes below; the rest are relative or indirect
    function automatic cad_kind_type dec_kind(input logic [7:0] o);
        cad_kind_type k;
        k = K_NOP;
        if (!o[7]) begin
            k = K_REL;
        end else begin
            unique case (o[7:4])
                CLS_CALL: k = K_CALL;
                CLS_JP: k = K_JP;
                CLS_BIT: k = K_BIT;
                CLS_BTB: k = K_BTB;
                CLS_SHORT: k = o[OP_SENSE_BIT] ? ((o == OP_RET) ? K_RET : K_NOP) : K_SHORT;
                CLS_DIRECT: begin
                    if (o == OP_LD_A_RR || o == OP_LD_RR_A) begin
                        k = K_DIRECT;
                    end else if (o == OP_LDI_A) begin
                        k = K_LDI_A;
                    end else if (o == OP_LDI_RR) begin
                        k = K_LDI_D;
                    end else begin
                        k = K_NOP;
                    end
                end
                default: k = K_IND;
            endcase
        end
        return k;
    endfunction

    function automatic logic [2:0] dec_cycles(input cad_kind_type k);
        logic [2:0] c;
        c = CYC_LS;
        unique case (k)
            K_REL: c = CYC_REL;
            K_RET, K_NOP: c = CYC_INH;
            K_CALL, K_JP: c = CYC_JMP;
            K_BIT: c = CYC_BIT;
            K_BTB: c = CYC_BTB;
            default: c = CYC_LS;
        endcase
        return c;
    endfunction

    // core registers live inside, the rest of the space is outside
    function automatic logic is_internal(input logic [7:0] a);
        return (a == ADDR_ACC) || (a[7:2] == WREG_PAGE);
    endfunction

    // ============================================================
    // next-state logic
    logic [7:0] rd_val;
    logic [7:0] wr_val;
    logic [7:0] ea;
    logic cond;
    logic [2:0] ncyc;
    logic last;

    always_comb begin
        next_pc = pc;
        next_ins_addr = ins_addr;
        next_op = op;
        next_b2 = b2;
        next_step = step + 3'h1;
        next_kind = kind;
        next_acc = acc;
        next_wreg = wreg;
        next_zf = zf;
        next_cf = cf;
        next_take = take;
        next_stack = stack;
        next_sp = sp;
        next_dreq = dreq;
        next_dreq.rd = 1'b0;
        next_dreq.wr = 1'b0;
        wr_val = 8'h00;
        ea = 8'h00;
        cond = 1'b0;
        ncyc = dec_cycles(kind);
        last = (step == ncyc - 3'h1);
        // value seen at the data address held during the access cycle
        if (dreq.addr == ADDR_ACC) begin
            rd_val = acc;
        end else if (dreq.addr[7:2] == WREG_PAGE) begin
            rd_val = wreg[dreq.addr[1:0]];
        end else begin
            rd_val = data_rdata_i;
        end
        unique case (step)
            3'h0: begin
                // opcode cycle: remember where the instruction starts
                next_op = prog_data_i;
                next_kind = dec_kind(prog_data_i);
                next_ins_addr = pc;
                next_pc = pc + 12'h001;
            end
            3'h1: begin
                // second cycle: operand byte two and the data address
                if (kind == K_REL) begin
                    unique case (op[6:5])
                        REL_NZ: cond = !zf;
                        REL_Z: cond = zf;
                        REL_NC: cond = !cf;
                        REL_C: cond = cf;
                    endcase
                    // forward reaches +1..+16, backward 0..-15
                    if (cond && !op[OP_DIR_BIT]) begin
                        next_pc = ins_addr + {8'h00, op[3:0]} + 12'h001;
                    end else if (cond) begin
                        next_pc = ins_addr - {8'h00, op[3:0]};
                    end // otherwise pc already points past the branch
                end else if (kind == K_RET) begin
                    if (sp != '0) begin
                        next_pc = stack[sp - 3'h1];
                        next_sp = sp - 3'h1;
                    end
                end else if (kind == K_SHORT || kind == K_IND || kind == K_NOP) begin
                    // one-byte forms fetch nothing more
                    if (kind == K_SHORT) begin
                        ea = ADDR_WREG_BASE | {6'h00, op[1:0]};
                    end else begin
                        ea = wreg[{1'b0, op[OP_PTR_BIT]}];
                    end
                    next_dreq.addr = ea;
                    // a no-op must never start a data read that lands in the next instruction
                    next_dreq.rd = !op[OP_STORE_BIT] && !is_internal(ea) && (kind != K_NOP);
                end else begin
                    // every other form carries a second byte
                    next_b2 = prog_data_i;
                    next_pc = pc + 12'h001;
                    // direct, bit and test forms address data by this byte
                    next_dreq.addr = prog_data_i;
                    next_dreq.rd = (kind == K_DIRECT && !op[OP_STORE_BIT])
                        || kind == K_BIT || kind == K_BTB;
                    next_dreq.rd = next_dreq.rd && !is_internal(prog_data_i);
                end
            end
            3'h2: begin
                // data cycle: read value settles, writes are prepared
                unique case (kind)
                    K_SHORT, K_IND, K_DIRECT: begin
                        if (op[OP_STORE_BIT]) begin
                            wr_val = acc;
                            next_zf = (acc == 8'h00);
                            next_dreq.wr = 1'b1;
                        end else begin
                            next_acc = rd_val;
                            next_zf = (rd_val == 8'h00);
                        end
                    end
                    K_LDI_A: begin
                        next_acc = b2;
                        next_zf = (b2 == 8'h00);
                    end
                    K_LDI_D: begin
                        // third byte is the source, flags untouched
                        next_pc = pc + 12'h001;
                        wr_val = prog_data_i;
                        next_dreq.addr = b2;
                        next_dreq.wr = 1'b1;
                    end
                    K_BIT: begin
                        next_cf = rd_val[op[2:0]];
                        wr_val = rd_val;
                        wr_val[op[2:0]] = op[OP_SENSE_BIT];
                        next_dreq.wr = 1'b1;
                    end
                    K_BTB: begin
                        // tested bit goes to carry, third byte is the displacement
                        next_cf = rd_val[op[2:0]];
                        next_take = (rd_val[op[2:0]] == op[OP_SENSE_BIT]);
                        next_b2 = prog_data_i;
                        next_pc = pc + 12'h001;
                    end
                    default: begin
                    end
                endcase
                // writes to core registers land here, others go out next cycle
                if (next_dreq.wr) begin
                    next_dreq.wdata = wr_val;
                    if (next_dreq.addr == ADDR_ACC) begin
                        next_acc = wr_val;
                        next_dreq.wr = 1'b0;
                    end else if (next_dreq.addr[7:2] == WREG_PAGE) begin
                        next_wreg[next_dreq.addr[1:0]] = wr_val;
                        next_dreq.wr = 1'b0;
                    end
                end
            end
            3'h3: begin
                if (kind == K_CALL || kind == K_JP) begin
                    next_pc = {op[3:0], b2};
                end
                if (kind == K_CALL) begin
                    // a full stack keeps its top cell for the newest return
                    if (sp == SP_W'(STACK_DEPTH)) begin
                        next_stack[STACK_DEPTH - 1] = ins_addr + 12'h002;
                    end else begin
                        next_stack[sp] = ins_addr + 12'h002;
                        next_sp = sp + 3'h1;
                    end
                end
            end
            default: begin
                // displacement taken relative to the opcode plus one
                if (kind == K_BTB && take) begin
                    next_pc = ins_addr + 12'h001 + {{4{b2[7]}}, b2};
                end
            end
        endcase
        if (last) begin
            next_step = 3'h0;
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc <= '0;
            ins_addr <= '0;
            op <= 8'h00;
            b2 <= 8'h00;
            step <= 3'h0;
            kind <= K_NOP;
            acc <= 8'h00;
            zf <= 1'b0;
            cf <= 1'b0;
            take <= 1'b0;
            sp <= '0;
            dreq <= '0;
            for (int i = 0; i < 4; i++) begin
                wreg[i] <= 8'h00;
            end
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= '0;
            end
        end else begin
            pc <= next_pc;
            ins_addr <= next_ins_addr;
            op <= next_op;
            b2 <= next_b2;
            step <= next_step;
            kind <= next_kind;
            acc <= next_acc;
            zf <= next_zf;
            cf <= next_cf;
            take <= next_take;
            sp <= next_sp;
            dreq <= next_dreq;
            wreg <= next_wreg;
            stack <= next_stack;
        end
    end

    // ============================================================
    // outputs, all straight from flip-flops
    assign prog_addr_o = pc;
    assign data_req_o = dreq;
    assign acc_o = acc;
    assign zero_o = zf;
    assign carry_o = cf;
    assign instr_addr_o = ins_addr;

endmodule
